// *** rtl/out_chan_map.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the output channel
// Assumes: 16-bit register data, byte offsets in steps of four
// Notes: Percent values are in hundredths, 10000 is full scale
`ifndef OUT_CHAN_MAP_SVH
`define OUT_CHAN_MAP_SVH

// Register offsets
`define A_OUT_CFG 8'h00
`define A_BLINK_MS 8'h04
`define A_HOT_CUR 8'h08
`define A_HOLD_CUR 8'h0c
`define A_HOT_MS 8'h10
`define A_FAULT_VAL 8'h14
`define A_REG_CFG 8'h18
`define A_CYCLE_MS 8'h1c
`define A_GAIN_G 8'h20
`define A_GAIN_KI 8'h24
`define A_GAIN_KD 8'h28
`define A_TI_MS 8'h2c
`define A_TD_MS 8'h30
`define A_TOL 8'h34
`define A_TGT_MIN 8'h38
`define A_TGT_SCALE 8'h3c
`define A_FB_MIN 8'h40
`define A_FB_SCALE 8'h44
`define A_STATUS 8'h48
`define A_RESULT 8'h4c

// Fields of the output configuration word
`define F_TYPE 2:0
`define F_DRESP 5:4
`define F_FRESP 7:6
`define F_FDET 8
`define F_SUPPLY 9
`define F_OTEMP 10
`define F_USEREG 11
// Fields of the regulator configuration word
`define F_REN 0
`define F_RRESP 2:1

// Output types
`define OT_OFF 3'h0
`define OT_CUR 3'h1
`define OT_HOT 3'h2
`define OT_VOLT 3'h3
`define OT_DIG 3'h4
`define OT_PWM 3'h5
// Digital responses
`define DR_NORMAL 2'h0
`define DR_INVERSE 2'h1
`define DR_LATCHED 2'h2
`define DR_BLINK 2'h3
// Fault responses
`define FR_OFF 2'h0
`define FR_VALUE 2'h1
`define FR_HOLD 2'h2
// Regulator responses
`define RR_SINGLE 2'h0
`define RR_SETPOINT 2'h1
`define RR_OVER 2'h2
`define RR_BELOW 2'h3

// Reset values
`define RST_BLINK_MS 16'h01f4
`define RST_CYCLE_MS 16'h000a
`define RST_GAIN_G 16'h0100

// Percent scale
`define PCT_FULL 16'h2710
`define PCT_HALF 16'h1388

// Timing
`define CLK_PERIOD_NS 4
`define MS_IN_NS 1000000
`define CYC_PER_MS (`MS_IN_NS / `CLK_PERIOD_NS)
`define RETRY_S 5
`define RETRY_MS (`RETRY_S * 1000)
`define DIV_STEPS 6'h2f

`endif

// *** rtl/out_chan_pkg.sv ***
// Purpose: Types of the output channel and its regulator
// Assumes: Constants live in out_chan_map.svh
// Notes: All state of the channel is one packed struct
package out_chan_pkg;

  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic we;
    logic re;
  } bus_req_s;

  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_DIV_I = 2'b01,
    PS_DIV_D = 2'b10,
    PS_CALC = 2'b11
  } pid_state_e;

  typedef struct packed {
    logic [2:0] out_type;
    logic [1:0] dig_resp;
    logic [1:0] fault_resp;
    logic fault_det;
    logic supply_opt;
    logic ot_en;
    logic use_reg;
    logic [15:0] blink_ms;
    logic [15:0] hot_cur;
    logic [15:0] hold_cur;
    logic [15:0] hot_ms;
    logic [15:0] fault_val;
    logic reg_en;
    logic [1:0] reg_resp;
    logic [15:0] cycle_ms;
    logic [15:0] gain_g;
    logic [15:0] gain_ki;
    logic [15:0] gain_kd;
    logic [15:0] ti_ms;
    logic [15:0] td_ms;
    logic [15:0] tol;
    logic [15:0] tgt_min;
    logic [15:0] tgt_scale;
    logic [15:0] fb_min;
    logic [15:0] fb_scale;
  } cfg_s;

  typedef struct packed {
    cfg_s cfg;
    logic [15:0] rdata;
    logic [23:0] ms_cnt;
    logic [15:0] blink_cnt;
    logic blink_ph;
    logic cmd_prev;
    logic latch_q;
    logic dig_prev;
    logic [15:0] hot_cnt;
    logic hot_act;
    logic short_q;
    logic [15:0] retry_cnt;
    logic drive_en;
    logic [15:0] drive_level;
    pid_state_e pid_st;
    logic [15:0] cyc_cnt;
    logic [47:0] div_num;
    logic [16:0] div_rem;
    logic [5:0] div_cnt;
    logic [23:0] igain;
    logic [23:0] dgain;
    logic [16:0] err;
    logic [16:0] err_prev;
    logic [31:0] esum;
    logic [15:0] result;
  } state_s;

endpackage

// *** rtl/output_response.sv ***
// Purpose: One output channel with digital responses, hotshot, fault reactions and a
//   closed loop regulator that may act as its command
// Assumes: All inputs synchronous to sys_clk; drive level is hundredths of percent or mA
// Notes: Notes on behaviour below
// Notes on behaviour
// - Normal response: output follows the command
// - Inverse response: output is opposite of command
// - Latched response: toggle on each command rise
// - Blinking: toggle at blink rate while on
// - Blinking only for plain digital type
// - Hotshot current for hotshot time, then hold
// - Current fault: off, fault value, or hold
// - Supply fault option disables output while present
// - Over temperature disables output while present
// - Hardware short detected: command output off
// - Retry shorted output every five seconds
// - Open load keeps being driven as commanded
// - Regulator result may drive the output
// - Regulator runs only when enabled
// - One regulator update per cycle time
// - Regulator response selector decodes over and below; single and setpoint both run the calculation
// - Target and feedback normalised to percent
// - Error below tolerance forced to zero
// - Proportional, integral and derivative terms computed
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "out_chan_map.svh"

module output_response #(
  parameter int CYCLES_PER_MS = `CYC_PER_MS,
  parameter int RETRY_MS = `RETRY_MS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire out_chan_pkg::bus_req_s bus,
  output logic [15:0] rdata,
  input wire logic cmd_level,
  input wire logic [15:0] cmd_value,
  input wire logic fault_flag,
  input wire logic supply_fault,
  input wire logic over_temp,
  input wire logic hw_short,
  input wire logic open_load,
  input wire logic [15:0] target_raw,
  input wire logic [15:0] feedback_raw,
  output logic drive_en,
  output logic [15:0] drive_level,
  output logic [15:0] regulator_result
);
  import out_chan_pkg::*;

  if (CYCLES_PER_MS < 2 || CYCLES_PER_MS > 16777215 || RETRY_MS < 1 || RETRY_MS > 65535)
  begin : g_bad_param
    $error("output_response: unsupported timing parameter");
  end

  state_s r;
  state_s n;

  logic ms_tick;
  logic cmd_on;
  logic [15:0] cmd_pct;
  logic cmd_rise;
  logic latch_nx;
  logic blink_ok;
  logic dig_on;
  logic shut_now;
  logic cur_fault;
  logic short_now;
  logic clean;
  logic base_en;
  logic [15:0] base_level;
  logic [15:0] tgt_pct;
  logic [15:0] fb_pct;
  logic [16:0] err_raw;
  logic [16:0] err_abs;
  logic [16:0] err_new;
  logic reg_upd;
  logic signed [32:0] sum_wide;
  logic [31:0] sum_sat;
  logic [16:0] rem_sh;
  logic [15:0] divisor;
  logic div_ge;
  logic [47:0] quot;
  logic [23:0] gain_sat;
  logic [47:0] num_i;
  logic [47:0] num_d;
  logic signed [33:0] term_p;
  logic signed [56:0] term_i;
  logic signed [42:0] term_d;
  logic signed [63:0] total;
  logic [15:0] calc_out;
  logic [15:0] cmp_out;

  ////////////////////////////////////////////////////////////////////////////////
  // Percent normalisation: (raw - min) * scale / 65536, clamped to full scale

  function automatic logic [15:0] to_pct(input logic [15:0] raw, input logic [15:0] mn,
                                         input logic [15:0] sc);
    logic [31:0] prod;
    prod = 32'h0;
    if (raw <= mn) begin
      to_pct = 16'h0;
    end else begin
      prod = (raw - mn) * sc;
      to_pct = (prod[31:16] > `PCT_FULL) ? `PCT_FULL : prod[31:16];
    end
  endfunction

  assign tgt_pct = to_pct(target_raw, r.cfg.tgt_min, r.cfg.tgt_scale);
  assign fb_pct = to_pct(feedback_raw, r.cfg.fb_min, r.cfg.fb_scale);

  ////////////////////////////////////////////////////////////////////////////////
  // Channel command and fault terms

  assign ms_tick = r.ms_cnt == 24'(CYCLES_PER_MS - 1);
  assign cmd_on = r.cfg.use_reg ? (r.result >= `PCT_HALF) : cmd_level;
  assign cmd_pct = r.cfg.use_reg ? r.result : cmd_value;
  assign cmd_rise = cmd_on & ~r.cmd_prev;
  assign latch_nx = r.latch_q ^ cmd_rise;
  assign blink_ok = r.cfg.out_type == `OT_DIG;
  assign shut_now = (r.cfg.supply_opt & supply_fault) | (r.cfg.ot_en & over_temp);
  assign cur_fault = (r.cfg.out_type == `OT_CUR || r.cfg.out_type == `OT_HOT)
                     & r.cfg.fault_det & fault_flag;
  assign short_now = r.short_q | (hw_short & r.drive_en);
  assign clean = ~shut_now & ~short_now & ~cur_fault;

  always_comb begin
    case (r.cfg.dig_resp)
      `DR_NORMAL: dig_on = cmd_on;
      `DR_INVERSE: dig_on = ~cmd_on;
      `DR_LATCHED: dig_on = latch_nx;
      `DR_BLINK: dig_on = blink_ok ? (cmd_on & r.blink_ph) : cmd_on;
      default: dig_on = cmd_on;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Regulator arithmetic

  assign err_raw = {1'b0, tgt_pct} - {1'b0, fb_pct};
  assign err_abs = err_raw[16] ? 17'(-err_raw) : err_raw;
  assign err_new = (err_abs < {1'b0, r.cfg.tol}) ? 17'h0 : err_raw;
  assign reg_upd = ms_tick && (r.cyc_cnt + 16'h1 >= r.cfg.cycle_ms);
  assign sum_wide = 33'(signed'(r.esum)) + 33'(signed'(err_new));
  assign sum_sat = (sum_wide > 33'sh040000000) ? 32'h40000000 :
                   (sum_wide < -33'sh040000000) ? 32'hc0000000 : sum_wide[31:0];
  assign num_i = 48'(r.cfg.gain_g) * 48'(r.cfg.gain_ki) * 48'(r.cfg.cycle_ms);
  assign num_d = 48'(r.cfg.gain_g) * 48'(r.cfg.gain_kd) * 48'(r.cfg.td_ms);
  assign divisor = (r.pid_st == PS_DIV_I) ? r.cfg.ti_ms :
                   ((r.cfg.cycle_ms == 16'h0) ? 16'h1 : r.cfg.cycle_ms);
  assign rem_sh = {r.div_rem[15:0], r.div_num[47]};
  assign div_ge = rem_sh >= {1'b0, divisor};
  assign quot = {r.div_num[46:0], div_ge};
  assign gain_sat = (quot[47:32] != 16'h0) ? 24'hffffff : quot[31:8];
  assign term_p = $signed({1'b0, r.cfg.gain_g}) * $signed(r.err);
  assign term_i = $signed({1'b0, r.igain}) * $signed(r.esum);
  assign term_d = $signed({1'b0, r.dgain})
                  * ($signed({r.err[16], r.err}) - $signed({r.err_prev[16], r.err_prev}));
  assign total = (64'(term_p) + 64'(term_i) + 64'(term_d)) >>> 8;
  assign calc_out = (total < 0) ? 16'h0 :
                    (total > 64'(`PCT_FULL)) ? `PCT_FULL : total[15:0];
  always_comb begin
    case (r.cfg.reg_resp)
      `RR_OVER: cmp_out = (fb_pct > tgt_pct) ? `PCT_FULL : 16'h0;
      `RR_BELOW: cmp_out = (fb_pct < tgt_pct) ? `PCT_FULL : 16'h0;
      default: cmp_out = 16'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = r;
    n.ms_cnt = ms_tick ? 24'h0 : r.ms_cnt + 24'h1;
    n.cmd_prev = cmd_on;
    n.latch_q = latch_nx;
    // Blink phase starts on and restarts whenever the command drops
    if (!cmd_on) begin
      n.blink_ph = 1'b1;
      n.blink_cnt = 16'h0;
    end else if (ms_tick) begin
      n.blink_cnt = r.blink_cnt + 16'h1;
      if (r.blink_cnt + 16'h1 >= r.cfg.blink_ms) begin
        n.blink_cnt = 16'h0;
        n.blink_ph = ~r.blink_ph;
      end
    end
    // Hotshot window opens on each switch-on
    n.dig_prev = dig_on;
    if (!dig_on) begin
      n.hot_act = 1'b0;
    end else if (!r.dig_prev) begin
      n.hot_act = 1'b1;
      n.hot_cnt = 16'h0;
    end else if (r.hot_act && ms_tick) begin
      n.hot_cnt = r.hot_cnt + 16'h1;
      if (r.hot_cnt + 16'h1 >= r.cfg.hot_ms) begin
        n.hot_act = 1'b0;
      end
    end
    case (r.cfg.out_type)
      `OT_OFF: begin
        base_en = 1'b0;
        base_level = 16'h0;
      end
      `OT_DIG: begin
        base_en = dig_on;
        base_level = dig_on ? `PCT_FULL : 16'h0;
      end
      `OT_HOT: begin
        base_en = dig_on;
        base_level = !dig_on ? 16'h0 : (n.hot_act ? r.cfg.hot_cur : r.cfg.hold_cur);
      end
      default: begin
        base_en = 1'b1;
        base_level = cmd_pct;
      end
    endcase
    // Faults are decided before the command; open load is only reported
    if (shut_now || short_now) begin
      n.drive_en = 1'b0;
      n.drive_level = 16'h0;
    end else if (cur_fault) begin
      case (r.cfg.fault_resp)
        `FR_OFF: begin
          n.drive_en = 1'b0;
          n.drive_level = 16'h0;
        end
        `FR_VALUE: begin
          n.drive_en = 1'b1;
          n.drive_level = r.cfg.fault_val;
        end
        default: begin
          n.drive_en = r.drive_en;
          n.drive_level = r.drive_level;
        end
      endcase
    end else begin
      n.drive_en = base_en;
      n.drive_level = base_level;
    end
    // Short retry timer
    if (r.short_q) begin
      if (ms_tick) begin
        n.retry_cnt = r.retry_cnt + 16'h1;
        if (r.retry_cnt == 16'(RETRY_MS - 1)) begin
          n.retry_cnt = 16'h0;
          n.short_q = ~base_en;
        end
      end
    end else if (hw_short && r.drive_en) begin
      n.short_q = 1'b1;
      n.retry_cnt = 16'h0;
    end
    // Regulator sequence
    if (!r.cfg.reg_en) begin
      n.pid_st = PS_IDLE;
      n.result = 16'h0;
      n.esum = 32'h0;
      n.err = 17'h0;
      n.err_prev = 17'h0;
      n.cyc_cnt = 16'h0;
    end else begin
      if (ms_tick) begin
        n.cyc_cnt = reg_upd ? 16'h0 : r.cyc_cnt + 16'h1;
      end
      case (r.pid_st)
        PS_IDLE: begin
          if (reg_upd) begin
            n.err_prev = r.err;
            n.err = err_new;
            n.esum = sum_sat;
            if (r.cfg.reg_resp == `RR_OVER || r.cfg.reg_resp == `RR_BELOW) begin
              n.result = cmp_out;
            end else begin
              n.div_num = num_i;
              n.div_rem = 17'h0;
              n.div_cnt = 6'h0;
              n.pid_st = PS_DIV_I;
            end
          end
        end
        PS_DIV_I, PS_DIV_D: begin
          n.div_num = quot;
          n.div_rem = div_ge ? rem_sh - {1'b0, divisor} : rem_sh;
          n.div_cnt = r.div_cnt + 6'h1;
          if (r.div_cnt == `DIV_STEPS) begin
            if (r.pid_st == PS_DIV_I) begin
              n.igain = (r.cfg.ti_ms == 16'h0) ? 24'h0 : gain_sat;
              n.div_num = num_d;
              n.div_rem = 17'h0;
              n.div_cnt = 6'h0;
              n.pid_st = PS_DIV_D;
            end else begin
              n.dgain = gain_sat;
              n.pid_st = PS_CALC;
            end
          end
        end
        PS_CALC: begin
          n.result = calc_out;
          n.pid_st = PS_IDLE;
        end
        default: n.pid_st = PS_IDLE;
      endcase
    end
    // Register port
    n.rdata = 16'h0;
    if (bus.we) begin
      case (bus.addr)
        `A_OUT_CFG: begin
          n.cfg.out_type = bus.wdata[`F_TYPE];
          n.cfg.dig_resp = bus.wdata[`F_DRESP];
          n.cfg.fault_resp = bus.wdata[`F_FRESP];
          n.cfg.fault_det = bus.wdata[`F_FDET];
          n.cfg.supply_opt = bus.wdata[`F_SUPPLY];
          n.cfg.ot_en = bus.wdata[`F_OTEMP];
          n.cfg.use_reg = bus.wdata[`F_USEREG];
        end
        `A_BLINK_MS: n.cfg.blink_ms = bus.wdata;
        `A_HOT_CUR: n.cfg.hot_cur = bus.wdata;
        `A_HOLD_CUR: n.cfg.hold_cur = bus.wdata;
        `A_HOT_MS: n.cfg.hot_ms = bus.wdata;
        `A_FAULT_VAL: n.cfg.fault_val = bus.wdata;
        `A_REG_CFG: begin
          n.cfg.reg_en = bus.wdata[`F_REN];
          n.cfg.reg_resp = bus.wdata[`F_RRESP];
        end
        `A_CYCLE_MS: n.cfg.cycle_ms = bus.wdata;
        `A_GAIN_G: n.cfg.gain_g = bus.wdata;
        `A_GAIN_KI: n.cfg.gain_ki = bus.wdata;
        `A_GAIN_KD: n.cfg.gain_kd = bus.wdata;
        `A_TI_MS: n.cfg.ti_ms = bus.wdata;
        `A_TD_MS: n.cfg.td_ms = bus.wdata;
        `A_TOL: n.cfg.tol = bus.wdata;
        `A_TGT_MIN: n.cfg.tgt_min = bus.wdata;
        `A_TGT_SCALE: n.cfg.tgt_scale = bus.wdata;
        `A_FB_MIN: n.cfg.fb_min = bus.wdata;
        `A_FB_SCALE: n.cfg.fb_scale = bus.wdata;
        default: ;
      endcase
    end
    if (bus.re) begin
      case (bus.addr)
        `A_OUT_CFG: n.rdata = {4'h0, r.cfg.use_reg, r.cfg.ot_en, r.cfg.supply_opt,
                               r.cfg.fault_det, r.cfg.fault_resp, r.cfg.dig_resp, 1'b0,
                               r.cfg.out_type};
        `A_BLINK_MS: n.rdata = r.cfg.blink_ms;
        `A_HOT_CUR: n.rdata = r.cfg.hot_cur;
        `A_HOLD_CUR: n.rdata = r.cfg.hold_cur;
        `A_HOT_MS: n.rdata = r.cfg.hot_ms;
        `A_FAULT_VAL: n.rdata = r.cfg.fault_val;
        `A_REG_CFG: n.rdata = {13'h0, r.cfg.reg_resp, r.cfg.reg_en};
        `A_CYCLE_MS: n.rdata = r.cfg.cycle_ms;
        `A_GAIN_G: n.rdata = r.cfg.gain_g;
        `A_GAIN_KI: n.rdata = r.cfg.gain_ki;
        `A_GAIN_KD: n.rdata = r.cfg.gain_kd;
        `A_TI_MS: n.rdata = r.cfg.ti_ms;
        `A_TD_MS: n.rdata = r.cfg.td_ms;
        `A_TOL: n.rdata = r.cfg.tol;
        `A_TGT_MIN: n.rdata = r.cfg.tgt_min;
        `A_TGT_SCALE: n.rdata = r.cfg.tgt_scale;
        `A_FB_MIN: n.rdata = r.cfg.fb_min;
        `A_FB_SCALE: n.rdata = r.cfg.fb_scale;
        `A_STATUS: n.rdata = {11'h0, cur_fault, shut_now, open_load, r.short_q, r.drive_en};
        `A_RESULT: n.rdata = r.result;
        default: n.rdata = 16'h0;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      r <= '0;
      r.cfg.blink_ms <= `RST_BLINK_MS;
      r.cfg.cycle_ms <= `RST_CYCLE_MS;
      r.cfg.gain_g <= `RST_GAIN_G;
    end else begin
      r <= n;
    end
  end

  assign rdata = r.rdata;
  assign drive_en = r.drive_en;
  assign drive_level = r.drive_level;
  assign regulator_result = r.result;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  chk_normal_follow: assert property (@(posedge sys_clk) disable iff (rst)
    (r.cfg.out_type == `OT_DIG && r.cfg.dig_resp == `DR_NORMAL && clean)
    |=> (drive_en == $past(cmd_on)))
    else $error("normal response does not follow command");

  chk_inverse_follow: assert property (@(posedge sys_clk) disable iff (rst)
    (r.cfg.out_type == `OT_DIG && r.cfg.dig_resp == `DR_INVERSE && clean)
    |=> (drive_en != $past(cmd_on)))
    else $error("inverse response not opposite of command");

  chk_latch_toggle: assert property (@(posedge sys_clk) disable iff (rst)
    (r.cfg.out_type == `OT_DIG && r.cfg.dig_resp == `DR_LATCHED && clean && cmd_rise
     && $past(clean) && !$past(rst))
    |=> (drive_en != $past(drive_en)))
    else $error("latched output did not toggle on command rise");

  chk_blink_off: assert property (@(posedge sys_clk) disable iff (rst)
    (r.cfg.dig_resp == `DR_BLINK && r.cfg.out_type == `OT_DIG && !cmd_on) |=> !drive_en)
    else $error("blinking output on while command off");

  chk_hot_noblink: assert property (@(posedge sys_clk) disable iff (rst)
    (r.cfg.out_type == `OT_HOT && r.cfg.dig_resp == `DR_BLINK && clean)
    |=> (drive_en == $past(cmd_on)))
    else $error("hotshot output blinks");

  chk_hot_start: assert property (@(posedge sys_clk) disable iff (rst)
    (r.cfg.out_type == `OT_HOT && r.cfg.hot_ms != 16'h0 && clean && dig_on && !r.dig_prev)
    |=> (drive_level == $past(r.cfg.hot_cur)) && drive_en)
    else $error("hotshot current not applied at switch-on");

  chk_fault_off: assert property (@(posedge sys_clk) disable iff (rst)
    (cur_fault && r.cfg.fault_resp == `FR_OFF) |=> !drive_en)
    else $error("current fault did not shut output");

  chk_supply_off: assert property (@(posedge sys_clk) disable iff (rst)
    (r.cfg.supply_opt && supply_fault) |=> (!drive_en && drive_level == 16'h0))
    else $error("supply fault did not disable output");

  chk_temp_off: assert property (@(posedge sys_clk) disable iff (rst)
    (r.cfg.ot_en && over_temp) [*2] |=> !drive_en)
    else $error("over temperature did not disable output");

  chk_short_off: assert property (@(posedge sys_clk) disable iff (rst)
    (hw_short && drive_en) |=> (!drive_en && r.short_q))
    else $error("short not taken off");

  chk_retry_time: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(r.short_q) |-> ($past(r.retry_cnt) == 16'(RETRY_MS - 1) && $past(ms_tick)))
    else $error("short retry at wrong time");

  chk_reg_idle: assert property (@(posedge sys_clk) disable iff (rst)
    !r.cfg.reg_en |=> (regulator_result == 16'h0 && r.pid_st == PS_IDLE))
    else $error("regulator active while disabled");

  chk_reg_range: assert property (@(posedge sys_clk) disable iff (rst)
    regulator_result <= `PCT_FULL)
    else $error("regulator result out of range");

  chk_over_mode: assert property (@(posedge sys_clk) disable iff (rst)
    (r.cfg.reg_en && r.pid_st == PS_IDLE && reg_upd && r.cfg.reg_resp == `RR_OVER
     && !bus.we)
    |=> (regulator_result == (($past(fb_pct) > $past(tgt_pct)) ? `PCT_FULL : 16'h0)))
    else $error("over target response wrong");

  chk_calc_done: assert property (@(posedge sys_clk) disable iff (rst || !r.cfg.reg_en)
    (r.pid_st == PS_DIV_I && r.div_cnt == 6'h0 && r.cfg.reg_en && !bus.we)
    |-> ##96 (r.pid_st == PS_CALC))
    else $error("regulator update did not finish in time");

endmodule

// *** bench/load_model.sv ***
// Purpose: Coil load seen by the output channel
// Assumes: Short, open and current fault are set by the bench
// Notes: A short trips only while the pin is driven
`timescale 1ns/100ps
module load_model (
  input wire logic sys_clk,
  input wire logic drive_en,
  input wire logic short_on,
  input wire logic open_on,
  input wire logic fault_on,
  output logic hw_short,
  output logic open_load,
  output logic fault_flag
);
  // Protection trips the cycle after drive meets a short
  always_ff @(posedge sys_clk) begin
    hw_short <= short_on & drive_en;
  end
  assign open_load = open_on;
  assign fault_flag = fault_on;
endmodule

// *** bench/output_response_tb.sv ***
// Purpose: Self-checking bench of output_response
// Assumes: Ten cycles per ms and a three ms retry
// Notes: Rows cover plain digital, hotshot and shutdown cases
`timescale 1ns/100ps
`include "out_chan_map.svh"
module output_response_tb;
  import out_chan_pkg::*;
  logic sys_clk = 0, rst = 1, cmd_level = 0, short_on = 0, open_on = 0, fault_on = 0;
  logic supply_fault = 0, over_temp = 0, drive_en, hw_short, open_load, fault_flag;
  logic [15:0] cmd_value = 16'h1000, rdata, drive_level, regulator_result, seen;
  logic [15:0] target_raw = 16'h0000, feedback_raw = 16'h0000;
  bus_req_s bus = '0;
  int n_errors = 0, n_tests = 0, cycles = 0;
  // Config word, then cmd, supply, temp, open and expected drive
  logic [20:0] rows [10] = '{{16'h0004, 5'b00000}, {16'h0004, 5'b10001},
    {16'h0014, 5'b00001}, {16'h0014, 5'b10000}, {16'h0032, 5'b10001},
    {16'h0032, 5'b00000}, {16'h0204, 5'b11000}, {16'h0404, 5'b10100},
    {16'h0004, 5'b11101}, {16'h0004, 5'b10011}};

  output_response #(.CYCLES_PER_MS(10), .RETRY_MS(3)) dut (
    .sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata), .cmd_level(cmd_level),
    .cmd_value(cmd_value), .fault_flag(fault_flag), .supply_fault(supply_fault),
    .over_temp(over_temp), .hw_short(hw_short), .open_load(open_load),
    .target_raw(target_raw), .feedback_raw(feedback_raw), .drive_en(drive_en),
    .drive_level(drive_level), .regulator_result(regulator_result));
  load_model load (.sys_clk(sys_clk), .drive_en(drive_en), .short_on(short_on),
    .open_on(open_on), .fault_on(fault_on), .hw_short(hw_short),
    .open_load(open_load), .fault_flag(fault_flag));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk) bus <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk) bus <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge sys_clk) bus <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge sys_clk) bus <= '0;
    #1 d = rdata;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic report_and_stop;
    if (n_errors == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    wait_n(1);
    chk("reset drive_en", drive_en, 16'h0000);
    chk("regulator off", regulator_result, 16'h0000);
    rd(`A_BLINK_MS, seen);
    chk("blink reset", seen, `RST_BLINK_MS);
    rd(`A_CYCLE_MS, seen);
    chk("cycle reset", seen, `RST_CYCLE_MS);
    rd(8'hfc, seen);
    chk("unmapped", seen, 16'h0000);
    foreach (rows[i]) begin
      wr(`A_OUT_CFG, rows[i][20:5]);
      @(posedge sys_clk) {cmd_level, supply_fault, over_temp, open_on} <= rows[i][4:1];
      wait_n(3);
      chk("row drive_en", drive_en, rows[i][0]);
    end
    // Mid-run reset clears any latch state left by the rows
    @(posedge sys_clk) {cmd_level, supply_fault, over_temp, open_on, rst} <= 5'b00001;
    wait_n(2);
    @(posedge sys_clk) rst <= 1'b0;
    wr(`A_OUT_CFG, 16'h0024);
    wait_n(3);
    chk("latch idle", drive_en, 16'h0000);
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk) cmd_level <= ~cmd_level;
      wait_n(3);
      chk("latch", drive_en, 16'(k < 2));
    end
    wr(`A_BLINK_MS, 16'h0002);
    wr(`A_OUT_CFG, 16'h0034);
    @(posedge sys_clk) cmd_level <= 1'b1;
    wait_n(3);
    chk("blink on", drive_en, 16'h0001);
    wait_n(20);
    chk("blink off", drive_en, 16'h0000);
    @(posedge sys_clk) cmd_level <= 1'b0;
    wait_n(25);
    chk("blink cmd off", drive_en, 16'h0000);
    wr(`A_HOT_CUR, 16'h07d0);
    wr(`A_HOLD_CUR, 16'h01f4);
    wr(`A_HOT_MS, 16'h0002);
    wr(`A_OUT_CFG, 16'h0002);
    @(posedge sys_clk) cmd_level <= 1'b1;
    wait_n(3);
    chk("hot level", drive_level, 16'h07d0);
    wait_n(40);
    chk("hold level", drive_level, 16'h01f4);
    wr(`A_FAULT_VAL, 16'h0064);
    wr(`A_OUT_CFG, 16'h0141);
    @(posedge sys_clk) fault_on <= 1'b1;
    wait_n(3);
    chk("fault value", drive_level, 16'h0064);
    wr(`A_OUT_CFG, 16'h0181);
    wait_n(3);
    chk("fault hold", drive_level, 16'h0064);
    wr(`A_OUT_CFG, 16'h0101);
    wait_n(3);
    chk("fault off", drive_en, 16'h0000);
    @(posedge sys_clk) fault_on <= 1'b0;
    wr(`A_OUT_CFG, 16'h0004);
    wait_n(3);
    @(posedge sys_clk) short_on <= 1'b1;
    wait_n(4);
    chk("short off", drive_en, 16'h0000);
    rd(`A_STATUS, seen);
    chk("short flag", seen & 16'h0002, 16'h0002);
    @(posedge sys_clk) short_on <= 1'b0;
    wait_n(10);
    chk("early retry", drive_en, 16'h0000);
    for (int k = 0; k < 60 && drive_en !== 1'b1; k++) begin
      wait_n(1);
    end
    chk("retry", drive_en, 16'h0001);
    // Regulator as command: target at half scale, feedback at quarter scale
    @(posedge sys_clk) {target_raw, feedback_raw} <= {16'h8000, 16'h4000};
    wr(`A_TGT_SCALE, `PCT_FULL);
    wr(`A_FB_SCALE, `PCT_FULL);
    wr(`A_CYCLE_MS, 16'h0001);
    wr(`A_OUT_CFG, 16'h0803);
    wr(`A_REG_CFG, 16'h0007);
    wait_n(25);
    chk("below target", regulator_result, `PCT_FULL);
    chk("reg command", drive_level, `PCT_FULL);
    wr(`A_REG_CFG, 16'h0005);
    wait_n(25);
    chk("over target", regulator_result, 16'h0000);
    wr(`A_REG_CFG, 16'h0001);
    wait_n(150);
    chk("single output", regulator_result, 16'h09c4);
    chk("reg level", drive_level, 16'h09c4);
    rd(`A_RESULT, seen);
    chk("result read", seen, 16'h09c4);
    wr(`A_REG_CFG, 16'h0000);
    wait_n(3);
    chk("reg disabled", regulator_result, 16'h0000);
    wr(`A_TOL, 16'h0bb8);
    wr(`A_REG_CFG, 16'h0001);
    wait_n(150);
    chk("tolerance", regulator_result, 16'h0000);
    report_and_stop();
  end
endmodule
